// ==== verilog/led_blink_sequencer.sv ====
// Blink sequencer for the red, green and blue outputs of the first group
// Behaviour
// - Blinking runs only when the output group select equals binary 01.
// - Cycle register bit 3 enables blinking per channel; zero disables it.
// - Writing start bit 3 restarts all enabled channels together.
// - Each channel output switch turns its output off regardless; when on, the output blinks or stays on.
// - Timing register holds ON code in bits 7-4, OFF code in 3-0.
// - Duration codes map to 0 through 100 percent of the cycle.
// - Cycle register bits 2-0 select period 0.1 s through 5 s.
// - Each cycle: OFF time, then ON time, then off for the rest.
// - OFF plus ON over full cycle: OFF kept, ON cut at cycle end.
// - OFF plus ON under full cycle: output off for the remainder.
// - Blinking exists only on the first group's three outputs.
// - A register write takes effect on the write strobe edge.
`timescale 1ns/100ps
`default_nettype none
module led_blink_sequencer #(
    parameter int TICK_CYCLES = led_blink_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Register write strobe, pulsed at the final acknowledge
    input wire led_blink_pkg::reg_write_type reg_wr,
    // Register read port
    input wire logic [7:0] reg_rd_addr,
    output logic [7:0] reg_rd_data,
    // Configuration bits held elsewhere in the device
    input wire logic [1:0] output_group_select,
    input wire logic red_output_switch,
    input wire logic green_output_switch,
    input wire logic blue_output_switch,
    // First LED group drive, index 0 red, 1 green, 2 blue
    output logic [2:0] first_led_group
);
    localparam int NC = led_blink_pkg::NUM_CHAN;

    // Write hit for a given offset
    function automatic logic write_hit(led_blink_pkg::reg_write_type w,
                                       logic [7:0] ofs);
        write_hit = w.we && (w.addr == ofs);
    endfunction : write_hit

    // Reset release through two flops
    logic [1:0] rst_sync_reg;
    logic rst_n;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // Registers
    logic [7:0] times_reg [NC];
    logic [7:0] cycle_reg [NC];
    logic [7:0] seq_ctrl_reg;
    logic [2:0] switches;
    logic group_blink;
    logic start_write;
    logic tick;
    logic [31:0] tick_cnt_reg;
    assign switches = {blue_output_switch, green_output_switch,
                       red_output_switch};
    assign group_blink = (output_group_select == led_blink_pkg::GROUP_BLINK);
    assign start_write = write_hit(reg_wr, led_blink_pkg::SEQ_CTRL_OFS)
        && reg_wr.data[led_blink_pkg::START_BIT];
    assign tick = (tick_cnt_reg == 32'(TICK_CYCLES - 1));

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            seq_ctrl_reg <= led_blink_pkg::REG_RESET;
        end else if (write_hit(reg_wr, led_blink_pkg::SEQ_CTRL_OFS)) begin
            seq_ctrl_reg <= reg_wr.data;
        end
    end

    // shared tick divider, restarted by start
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_reg <= 32'h0000_0000;
        end else if (start_write || tick) begin
            tick_cnt_reg <= 32'h0000_0000;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
        end
    end

    // Read data selection
    logic [7:0] rd_next;
    always_comb begin
        rd_next = 8'h00;
        for (int c = 0; c < NC; c++) begin
            if (reg_rd_addr == led_blink_pkg::TIMES_OFS[c]) begin
                rd_next = times_reg[c];
            end
            if (reg_rd_addr == led_blink_pkg::CYCLE_OFS[c]) begin
                rd_next = cycle_reg[c];
            end
        end
        if (reg_rd_addr == led_blink_pkg::SEQ_CTRL_OFS) begin
            rd_next = seq_ctrl_reg;
        end
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rd_data <= 8'h00;
        end else begin
            reg_rd_data <= rd_next;
        end
    end

    // Per-channel state
    logic [13:0] pos_reg [NC];
    logic [13:0] period [NC];
    logic active [NC];
    logic wave [NC];
    logic [2:0] led_next;

    // only the three first-group channels exist
    for (genvar c = 0; c < NC; c++) begin : g_chan
        logic [8:0] off_hp;
        logic [8:0] end_hp;
        logic [23:0] pos_scaled;
        logic [23:0] off_edge;
        logic [23:0] on_edge;
        logic blink_en;

        always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
                times_reg[c] <= led_blink_pkg::REG_RESET;
                cycle_reg[c] <= led_blink_pkg::REG_RESET;
            end else begin
                if (write_hit(reg_wr, led_blink_pkg::TIMES_OFS[c])) begin
                    times_reg[c] <= reg_wr.data;
                end
                if (write_hit(reg_wr, led_blink_pkg::CYCLE_OFS[c])) begin
                    cycle_reg[c] <= reg_wr.data;
                end
            end
        end

        assign blink_en = cycle_reg[c][led_blink_pkg::BLINK_EN_BIT];
        assign active[c] = group_blink && blink_en
            && seq_ctrl_reg[led_blink_pkg::START_BIT];
        assign period[c] = led_blink_pkg::PERIOD_TICKS[
            cycle_reg[c][led_blink_pkg::PERIOD_CODE_LSB +: 3]];
        assign off_hp = {1'b0, led_blink_pkg::FRACTION_HALF_PCT[
            times_reg[c][led_blink_pkg::OFF_CODE_LSB +: 4]]};
        assign end_hp = off_hp + {1'b0, led_blink_pkg::FRACTION_HALF_PCT[
            times_reg[c][led_blink_pkg::ON_CODE_LSB +: 4]]};
        assign pos_scaled = 24'(pos_reg[c])
            * 24'(led_blink_pkg::FULL_HALF_PCT);
        assign off_edge = 24'(period[c]) * 24'(off_hp);
        assign on_edge = 24'(period[c]) * 24'(end_hp);
        // off, on, off; pos stays below period
        assign wave[c] = (pos_scaled >= off_edge) && (pos_scaled < on_edge);

        always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
                pos_reg[c] <= 14'h0000;
            end else if (start_write || !active[c]) begin
                pos_reg[c] <= 14'h0000;
            end else if (tick) begin
                if (pos_reg[c] >= period[c] - 14'h0001) begin
                    pos_reg[c] <= 14'h0000;
                end else begin
                    pos_reg[c] <= pos_reg[c] + 14'h0001;
                end
            end
        end

        // switch gates the output in every mode
        assign led_next[c] = switches[c] && (active[c] ? wave[c] : 1'b1);
    end

    // Output drive register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            first_led_group <= 3'b000;
        end else begin
            first_led_group <= led_next;
        end
    end

    // Checks
    sequence s_start_written;
        start_write;
    endsequence
    sequence s_restarted;
        pos_reg[0] == 14'h0000 && pos_reg[1] == 14'h0000
            && pos_reg[2] == 14'h0000 && tick_cnt_reg == 32'h0000_0000;
    endsequence

    property p_group_gate;
        @(posedge core_clk) disable iff (!rst_n)
        rst_n && !group_blink |=> first_led_group == $past(switches);
    endproperty
    a_group_gate: assert property (p_group_gate)
        else $error("group other than 01 must follow switches");

    property p_blink_disabled;
        @(posedge core_clk) disable iff (!rst_n)
        rst_n && !cycle_reg[1][led_blink_pkg::BLINK_EN_BIT]
            |=> first_led_group[1] == $past(switches[1]);
    endproperty
    a_blink_disabled: assert property (p_blink_disabled)
        else $error("disabled channel must follow its switch");

    property p_start_sync;
        @(posedge core_clk) disable iff (!rst_n)
        s_start_written |=> s_restarted;
    endproperty
    a_start_sync: assert property (p_start_sync)
        else $error("start did not restart all channels together");

    property p_switch_off;
        @(posedge core_clk) disable iff (!rst_n)
        !switches[2] |=> !first_led_group[2];
    endproperty
    a_switch_off: assert property (p_switch_off)
        else $error("switched-off output is driven");

    property p_times_write;
        @(posedge core_clk) disable iff (!rst_n)
        write_hit(reg_wr, led_blink_pkg::TIMES_OFS[0])
            |=> times_reg[0] == $past(reg_wr.data);
    endproperty
    a_times_write: assert property (p_times_write)
        else $error("timing write not taken at the strobe");

    property p_first_off;
        @(posedge core_clk) disable iff (!rst_n)
        active[0] && g_chan[0].pos_scaled < g_chan[0].off_edge
            |=> !first_led_group[0];
    endproperty
    a_first_off: assert property (p_first_off)
        else $error("output on during the OFF phase");

    property p_tail_off;
        @(posedge core_clk) disable iff (!rst_n)
        active[0] && g_chan[0].pos_scaled >= g_chan[0].on_edge
            |=> !first_led_group[0];
    endproperty
    a_tail_off: assert property (p_tail_off)
        else $error("output on after the ON phase");

    property p_on_phase;
        @(posedge core_clk) disable iff (!rst_n)
        active[0] && switches[0] && g_chan[0].pos_scaled >= g_chan[0].off_edge
            && g_chan[0].pos_scaled < g_chan[0].on_edge
            |=> first_led_group[0];
    endproperty
    a_on_phase: assert property (p_on_phase)
        else $error("output off during the ON phase");

    property p_wrap;
        @(posedge core_clk) disable iff (!rst_n)
        active[0] && !start_write && tick
            && pos_reg[0] == period[0] - 14'h0001
            |=> pos_reg[0] == 14'h0000;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("cycle did not wrap at the period end");

    property p_period_code0;
        @(posedge core_clk) disable iff (!rst_n)
        cycle_reg[0][2:0] == 3'h0 |-> period[0] == 14'h00C8;
    endproperty
    a_period_code0: assert property (p_period_code0)
        else $error("shortest period is not 200 ticks");

    property p_pos_bound;
        @(posedge core_clk) disable iff (!rst_n)
        active[0] && $stable(cycle_reg[0]) |-> pos_reg[0] < period[0]
            || $changed(cycle_reg[0]);
    endproperty
    a_pos_bound: assert property (p_pos_bound)
        else $error("cycle position passed the period");
endmodule : led_blink_sequencer
`default_nettype wire

// ==== verilog/led_blink_pkg.sv ====
// Constants, tables and carrier types for the LED blink sequencer
package led_blink_pkg;
    // Channel count: red, green, blue of the first LED group
    localparam int NUM_CHAN = 3;
    // Register offsets
    localparam logic [7:0] TIMES_OFS [NUM_CHAN] = '{8'h01, 8'h03, 8'h05};
    localparam logic [7:0] CYCLE_OFS [NUM_CHAN] = '{8'h02, 8'h04, 8'h06};
    localparam logic [7:0] SEQ_CTRL_OFS = 8'h11;
    // Register reset value
    localparam logic [7:0] REG_RESET = 8'h00;
    // Field positions
    localparam int ON_CODE_LSB = 4;
    localparam int OFF_CODE_LSB = 0;
    localparam int BLINK_EN_BIT = 3;
    localparam int PERIOD_CODE_LSB = 0;
    localparam int START_BIT = 3;
    // Group selection value that routes blinking to the first group
    localparam logic [1:0] GROUP_BLINK = 2'h1;
    // Base time step: a period is split into ticks of this length
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_US = 500;
    localparam int TICK_CYCLES = TICK_US * 1000 / CLK_PERIOD_NS;
    // Fractions are in half-percent units, full cycle is this many
    localparam logic [8:0] FULL_HALF_PCT = 9'h0C8;
    // Period in ticks for period codes 0..7 (0.1 s to 5 s)
    localparam logic [13:0] PERIOD_TICKS [8] = '{
        14'h00C8, 14'h01F4, 14'h03E8, 14'h07D0,
        14'h0FA0, 14'h1770, 14'h1F40, 14'h2710};
    // Half-percent fraction for duration codes 0..15 (0 % to 100 %)
    localparam logic [7:0] FRACTION_HALF_PCT [16] = '{
        8'h00, 8'h02, 8'h05, 8'h0A, 8'h0F, 8'h14, 8'h1E, 8'h28,
        8'h3C, 8'h50, 8'h64, 8'h78, 8'h8C, 8'hA0, 8'hB4, 8'hC8};
    // Register write strobe from the serial interface
    typedef struct packed {
        logic we;
        logic [7:0] addr;
        logic [7:0] data;
    } reg_write_type;
endpackage : led_blink_pkg

// ==== testbench/led_blink_sequencer_tb.sv ====
// Self-checking bench for the LED blink sequencer
`timescale 1ns/100ps
`default_nettype none
module led_blink_sequencer_tb;
    localparam int TICK = 2;
    typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] r;} row_type;
    logic core_clk;
    logic resetn;
    led_blink_pkg::reg_write_type reg_wr;
    logic [7:0] reg_rd_addr;
    logic [7:0] reg_rd_data;
    logic [1:0] output_group_select;
    logic red_output_switch;
    logic green_output_switch;
    logic blue_output_switch;
    logic [2:0] first_led_group;
    int errors;
    int samples_checked;
    int prev;
    // Duration fractions in half-percent units, periods in ticks
    int hp [16] = '{0, 2, 5, 10, 15, 20, 30, 40, 60, 80, 100, 120, 140,
        160, 180, 200};
    int pt [8] = '{200, 500, 1000, 2000, 4000, 6000, 8000, 10000};
    int pts [11] = '{20, 100, 250, 300, 380, 420, 500, 700, 900, 1100, 1300};
    // Writes with readback; unmapped places read zero
    row_type rows [9] = '{'{8'h01, 8'hA5, 8'hA5}, '{8'h02, 8'h0F, 8'h0F},
        '{8'h03, 8'h5A, 8'h5A}, '{8'h04, 8'hF7, 8'hF7},
        '{8'h05, 8'h3C, 8'h3C}, '{8'h06, 8'hC3, 8'hC3},
        '{8'h11, 8'hFF, 8'hFF}, '{8'h07, 8'h77, 8'h00},
        '{8'h10, 8'h55, 8'h00}};

    led_blink_sequencer #(.TICK_CYCLES(TICK)) DUT (
        .core_clk(core_clk),
        .resetn(resetn),
        .reg_wr(reg_wr),
        .reg_rd_addr(reg_rd_addr),
        .reg_rd_data(reg_rd_data),
        .output_group_select(output_group_select),
        .red_output_switch(red_output_switch),
        .green_output_switch(green_output_switch),
        .blue_output_switch(blue_output_switch),
        .first_led_group(first_led_group)
    );

    // Clock at 100 MHz
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One-cycle register write pulse
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_wr = '{1'b1, a, d};
        @(negedge core_clk);
        reg_wr.we = 1'b0;
    endtask : wr

    // Read with one cycle of latency
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk);
        reg_rd_addr = a;
        @(negedge core_clk);
        d = reg_rd_data;
    endtask : rd

    // Expected level: OFF span, ON span, then off to the cycle end
    // Output register adds one clock behind the cycle position
    function automatic logic exp_on(int c, int p, int off, int on);
        int pos;
        pos = ((c - 1) / TICK) % p;
        return (pos * 200 >= p * off) && (pos * 200 < p * (off + on));
    endfunction : exp_on

    task automatic summarize();
        $display("checked %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize

    // Watchdog, run needs about 16 us
    initial begin
        #100000;
        errors++;
        summarize();
    end

    // Main sequence
    initial begin
        logic [7:0] v;
        errors = 0;
        samples_checked = 0;
        resetn = 1'b0;
        reg_wr = '0;
        reg_rd_addr = 8'h01;
        output_group_select = 2'h0;
        red_output_switch = 1'b1;
        green_output_switch = 1'b1;
        blue_output_switch = 1'b1;
        repeat (4) @(negedge core_clk);
        check({5'h0, first_led_group}, 8'h00);
        check(reg_rd_data, 8'h00);
        resetn = 1'b1;
        repeat (4) @(negedge core_clk);
        // Group not selected: switches give steady on
        check({5'h0, first_led_group}, 8'h07);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, v);
            check(v, rows[i].r);
        end
        // Red 10/30 at 0.1 s, green 50/100 at 0.25 s, blue disabled
        output_group_select = 2'h1;
        wr(8'h01, 8'h85);
        wr(8'h02, 8'h08);
        wr(8'h03, 8'hFA);
        wr(8'h04, 8'h09);
        wr(8'h05, 8'hFF);
        wr(8'h06, 8'h00);
        wr(8'h11, 8'h08);
        prev = 0;
        foreach (pts[i]) begin
            repeat (pts[i] - prev) @(negedge core_clk);
            prev = pts[i];
            check({5'h0, first_led_group}, {5'h0, 1'b1,
                exp_on(pts[i], pt[1], hp[10], hp[15]),
                exp_on(pts[i], pt[0], hp[5], hp[8])});
        end
        // Other group selection stops blinking
        output_group_select = 2'h2;
        repeat (3) @(negedge core_clk);
        check({5'h0, first_led_group}, 8'h07);
        // Switch off overrides a running blink
        output_group_select = 2'h1;
        red_output_switch = 1'b0;
        blue_output_switch = 1'b0;
        repeat (4) begin
            repeat (53) @(negedge core_clk);
            check({7'h0, first_led_group[0]}, 8'h00);
            check({7'h0, first_led_group[2]}, 8'h00);
        end
        blue_output_switch = 1'b1;
        // Start bit cleared: steady switch levels
        wr(8'h11, 8'h00);
        repeat (3) @(negedge core_clk);
        check({5'h0, first_led_group}, 8'h06);
        // Reset in mid-run clears outputs and registers
        resetn = 1'b0;
        @(negedge core_clk);
        check({5'h0, first_led_group}, 8'h00);
        resetn = 1'b1;
        repeat (4) @(negedge core_clk);
        rd(8'h03, v);
        check(v, 8'h00);
        summarize();
    end
endmodule : led_blink_sequencer_tb
`default_nettype wire
